// ### udh_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef UDH_REGS_SVH
`define UDH_REGS_SVH

// ***********************************************
// register offsets on registerAddress
// ***********************************************
`define UDH_REG_DATA     3'h0
`define UDH_REG_CTRL     3'h1
`define UDH_REG_DIVLO    3'h2
`define UDH_REG_DIVHI    3'h3
`define UDH_REG_MCTRL    3'h4
`define UDH_REG_STAT     3'h5
`define UDH_REG_THRESH   3'h6
`define UDH_REG_SPECIAL  3'h7

// ***********************************************
// field positions
// ***********************************************
`define UDH_MCTRL_INTEN  3
`define UDH_STAT_RXAVAIL 0
`define UDH_STAT_TXFULL  1
`define UDH_STAT_TXEMPTY 2
`define UDH_STAT_SPECIAL 3
`define UDH_STAT_XOFF    4
`define UDH_STAT_OVERRUN 5

// ***********************************************
// reset values and flow characters
// ***********************************************
`define UDH_CTRL_RST     8'h00
`define UDH_DIV_RST      16'h0001
`define UDH_MCTRL_RST    8'h00
`define UDH_THRESH_RST   8'h81
`define UDH_SPECIAL_RST  8'h00
`define UDH_XON_CHAR     8'h11
`define UDH_XOFF_CHAR    8'h13

// ***********************************************
// fifo sizes and timing counts
// ***********************************************
`define UDH_FIFO_DEPTH   16
`define UDH_FIFO_FULL    5'h10
`define UDH_OVS_LAST     4'hf
`define UDH_OVS_MID      4'h7
`define UDH_PRE4_LAST    2'h3

`endif

// ### udh_pkg.sv
// shared types of the dual style serial controller
package udh_pkg;

   // ***********************************************
   // control register layout
   // ***********************************************
   typedef struct packed {
      logic [3:0] spare;
      logic       txIntEn;
      logic       rxIntEn;
      logic       flowEn;
      logic       prescale4;
   } udh_ctrl_s;

   // ***********************************************
   // serial state machines
   // ***********************************************
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} udh_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} udh_rx_e;

endpackage : udh_pkg

// ### udh_fifo.sv
// sixteen byte flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "udh_regs.svh"

module udh_fifo (
   // clock, enable, reset
   input  wire logic       mclk,
   input  wire logic       clkEn,
   input  wire logic       rst,
   // fill side
   input  wire logic       wValid,
   output logic            wReady,
   input  wire logic [7:0] wData,
   // drain side
   output logic            rValid,
   input  wire logic       rReady,
   output logic [7:0]      rData,
   // fill level
   output logic [4:0]      count
);

   logic [7:0] mem_q [0:`UDH_FIFO_DEPTH-1];
   logic [3:0] wIdx_q;
   logic [3:0] rIdx_q;
   logic [4:0] count_q;
   logic       push;
   logic       pop;

   // honest flags from the fill count
   assign wReady = (count_q != `UDH_FIFO_FULL);
   assign rValid = (count_q != 5'h00);
   assign rData  = mem_q[rIdx_q];
   assign count  = count_q;
   assign push   = wValid & wReady;
   assign pop    = rValid & rReady;

   // storage needs no reset, pointers guard it
   always_ff @(posedge mclk) begin
      if (clkEn && push) begin
         mem_q[wIdx_q] <= wData;
      end
   end

   // pointers and count
   always_ff @(posedge mclk) begin
      if (rst) begin
         wIdx_q  <= 4'h0;
         rIdx_q  <= 4'h0;
         count_q <= 5'h00;
      end else if (clkEn) begin
         if (push) wIdx_q <= wIdx_q + 4'h1;
         if (pop)  rIdx_q <= rIdx_q + 4'h1;
         if (push && !pop)      count_q <= count_q + 5'h01;
         else if (pop && !push) count_q <= count_q - 5'h01;
      end
   end

endmodule : udh_fifo

// ### udh_uart_core.sv
// serial controller with selectable strobe or direction style host port
//
// Summary of operation
// - strobe style: chip select with separate low read and write strobes
// - direction style: chip select with one read/write direction input
// - reset pin high-active in strobe style, low-active in direction style
// - during reset transmit idles high, receive ignored, outputs at reset
// - sixteen byte transmit fifo and sixteen byte receive fifo
// - separate transmit and receive fill thresholds drive service requests
// - prescaler divides clock by one or four before the divisor
// - sixteen times oversampling clock times transmit and receive bits
// - xon/xoff pause and resume transmit; detect a programmable special character
// - strobe style host uses read strobe, write strobe and chip select
// - direction style ignores read strobe; only chip select and direction used
// - falling read strobe starts read of addressed register, byte then driven
// - falling write strobe begins write; rising edge stores the byte
// - direction input high requests read, low requests write
// - strobe style interrupt high, enabled by bit 3; else open-drain low
`timescale 1ns/1ps
`include "udh_regs.svh"

module udh_uart_core (
   // clock, enable, system reset
   input  wire logic       mclk,
   input  wire logic       clkEn,
   input  wire logic       rst,
   // host bus style and reset pin
   input  wire logic       busStyleSel,
   input  wire logic       hostResetPin,
   // host bus strobes and address
   input  wire logic       chipSelN,
   input  wire logic       readStrobeN,
   input  wire logic       writeStrobeN,
   input  wire logic [2:0] registerAddress,
   // host data bus, split two-way pin
   input  wire logic [7:0] dataIn,
   output logic [7:0]      dataOut,
   output logic            dataOe,
   // interrupt pin, split three-state pin
   output logic            intOut,
   output logic            intOe,
   // serial lines
   output logic            txd,
   input  wire logic       rxd
);

   // ***********************************************
   // host pin synchronisers and reset
   // ***********************************************
   logic [3:0] pinMeta_q;
   logic [3:0] pinSync_q;
   logic       rdPrev_q;
   logic       wrPrev_q;
   logic       resetLvl;
   logic       hostRst;
   logic       coreRst;
   logic       csAct;
   logic       rdAct;
   logic       wrAct;
   logic       rdStart;
   logic       wrDone;

   // two flop sync; first stage read by second only
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinMeta_q <= 4'h7;
         pinSync_q <= 4'h7;
      end else if (clkEn) begin
         pinMeta_q <= {hostResetPin, chipSelN, readStrobeN, writeStrobeN};
         pinSync_q <= pinMeta_q;
      end
   end

   // reset polarity follows the bus style
   assign resetLvl = pinSync_q[3];
   assign hostRst  = busStyleSel ? resetLvl : ~resetLvl;
   assign coreRst  = rst | hostRst;

   assign csAct = ~pinSync_q[2];
   // strobe style reads on a low read strobe; direction style ignores it, direction high reads
   assign rdAct = busStyleSel ? (csAct & ~pinSync_q[1]) : (csAct & pinSync_q[0]);
   // write strobe low, or direction low, writes
   assign wrAct = csAct & ~pinSync_q[0];
   // read begins on the leading edge
   assign rdStart = rdAct & ~rdPrev_q;
   // write lands on the trailing edge
   assign wrDone  = ~wrAct & wrPrev_q;

   // edge history of the access levels
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         rdPrev_q <= 1'b0;
         wrPrev_q <= 1'b0;
      end else if (clkEn) begin
         rdPrev_q <= rdAct;
         wrPrev_q <= wrAct;
      end
   end

   // ***********************************************
   // registers
   // ***********************************************
   udh_pkg::udh_ctrl_s ctrl_q;
   logic [15:0] divisor_q;
   logic [7:0]  mctrl_q;
   logic [7:0]  thresh_q;
   logic [7:0]  special_q;
   logic [7:0]  dataOut_q;
   logic [7:0]  readVal;
   logic [7:0]  statVal;
   logic        specialFlag_q;
   logic        overrun_q;
   logic        xoffHeld_q;
   logic        wrData;
   logic        rdData;
   logic        rdStat;
   logic        specialHit;
   logic        overrunHit;
   logic        xonHit;
   logic        xoffHit;

   // write and read selects
   assign wrData = wrDone  && (registerAddress == `UDH_REG_DATA);
   assign rdData = rdStart && (registerAddress == `UDH_REG_DATA);
   assign rdStat = rdStart && (registerAddress == `UDH_REG_STAT);

   // config registers; data bus captured as the write ends
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         ctrl_q    <= `UDH_CTRL_RST;
         divisor_q <= `UDH_DIV_RST;
         mctrl_q   <= `UDH_MCTRL_RST;
         thresh_q  <= `UDH_THRESH_RST;
         special_q <= `UDH_SPECIAL_RST;
      end else if (clkEn && wrDone) begin
         if (registerAddress == `UDH_REG_CTRL)         ctrl_q          <= dataIn;
         else if (registerAddress == `UDH_REG_DIVLO)   divisor_q[7:0]  <= dataIn;
         else if (registerAddress == `UDH_REG_DIVHI)   divisor_q[15:8] <= dataIn;
         else if (registerAddress == `UDH_REG_MCTRL)   mctrl_q         <= dataIn;
         else if (registerAddress == `UDH_REG_THRESH)  thresh_q        <= dataIn;
         else if (registerAddress == `UDH_REG_SPECIAL) special_q       <= dataIn;
      end
   end

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         specialFlag_q <= 1'b0;
         overrun_q     <= 1'b0;
         xoffHeld_q    <= 1'b0;
      end else if (clkEn) begin
         specialFlag_q <= specialHit | (specialFlag_q & ~rdStat);
         overrun_q     <= overrunHit | (overrun_q & ~rdStat);
         xoffHeld_q    <= ctrl_q.flowEn & (xoffHit | (xoffHeld_q & ~xonHit));
      end
   end

   // ***********************************************
   // fifos
   // ***********************************************
   logic       txRValid;
   logic       txPop;
   logic [7:0] txRData;
   logic [4:0] txCount;
   logic       txWReady;
   logic       rxRValid;
   logic [7:0] rxRData;
   logic [4:0] rxCount;
   logic       rxWReady;
   logic       rxPush_q;
   logic [7:0] rxByte_q;

   // transmit fifo; a write to a full fifo is dropped
   udh_fifo txFifo (
      .mclk   (mclk),
      .clkEn  (clkEn),
      .rst    (coreRst),
      .wValid (wrData),
      .wReady (txWReady),
      .wData  (dataIn),
      .rValid (txRValid),
      .rReady (txPop),
      .rData  (txRData),
      .count  (txCount)
   );

   // receive fifo, drained by data register reads
   udh_fifo rxFifo (
      .mclk   (mclk),
      .clkEn  (clkEn),
      .rst    (coreRst),
      .wValid (rxPush_q),
      .wReady (rxWReady),
      .wData  (rxByte_q),
      .rValid (rxRValid),
      .rReady (rdData),
      .rData  (rxRData),
      .count  (rxCount)
   );

   // status word
   assign statVal = {2'b00, overrun_q, xoffHeld_q, specialFlag_q,
                     (txCount == 5'h00), ~txWReady, rxRValid};

   // read mux, sampled at the leading edge
   always_comb begin
      if (registerAddress == `UDH_REG_DATA)         readVal = rxRData;
      else if (registerAddress == `UDH_REG_CTRL)    readVal = ctrl_q;
      else if (registerAddress == `UDH_REG_DIVLO)   readVal = divisor_q[7:0];
      else if (registerAddress == `UDH_REG_DIVHI)   readVal = divisor_q[15:8];
      else if (registerAddress == `UDH_REG_MCTRL)   readVal = mctrl_q;
      else if (registerAddress == `UDH_REG_STAT)    readVal = statVal;
      else if (registerAddress == `UDH_REG_THRESH)  readVal = thresh_q;
      else                                          readVal = special_q;
   end

   // hold the read byte for the rest of the strobe
   always_ff @(posedge mclk) begin
      if (coreRst) dataOut_q <= 8'h00;
      else if (clkEn && rdStart) dataOut_q <= readVal;
   end
   assign dataOut = dataOut_q;
   assign dataOe  = rdAct & ~coreRst;

   // ***********************************************
   // interrupt pin
   // ***********************************************
   logic irq;
   // thresholds: rx at or above, tx at or below
   assign irq = (ctrl_q.rxIntEn & (rxCount >= {1'b0, thresh_q[3:0]}))
              | (ctrl_q.txIntEn & (txCount <= {1'b0, thresh_q[7:4]}))
              | specialFlag_q;
   // active high gated by bit 3, or open-drain low
   assign intOut = busStyleSel ? irq : 1'b0;
   assign intOe  = busStyleSel ? mctrl_q[`UDH_MCTRL_INTEN] : irq;

   // ***********************************************
   // baud generator
   // ***********************************************
   logic [1:0]  pre_q;
   logic [15:0] divCnt_q;
   logic [15:0] divLast;
   logic        preTick;
   logic        tick16;

   assign preTick = ctrl_q.prescale4 ? (pre_q == `UDH_PRE4_LAST) : 1'b1;
   // divisor of zero treated as one
   assign divLast = (divisor_q == 16'h0000) ? 16'h0000 : divisor_q - 16'h0001;
   // at or above, so a divisor lowered mid-count never strands the counter
   assign tick16  = preTick && (divCnt_q >= divLast);

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         pre_q    <= 2'h0;
         divCnt_q <= 16'h0000;
      end else if (clkEn) begin
         pre_q <= pre_q + 2'h1;
         if (tick16) divCnt_q <= 16'h0000;
         else if (preTick) divCnt_q <= divCnt_q + 16'h0001;
      end
   end

   // ***********************************************
   // transmitter
   // ***********************************************
   udh_pkg::udh_tx_e txState_q;
   logic [3:0] txTick_q;
   logic [2:0] txBit_q;
   logic [7:0] txShift_q;
   logic       txd_q;
   logic       txGo;

   // no new byte starts while paused
   assign txGo  = tick16 && txRValid && !xoffHeld_q;
   assign txPop = (txState_q == udh_pkg::TX_IDLE) && txGo;
   assign txd   = txd_q;

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         txState_q <= udh_pkg::TX_IDLE;
         txTick_q  <= 4'h0;
         txBit_q   <= 3'h0;
         txShift_q <= 8'h00;
         txd_q     <= 1'b1;
      end else if (clkEn && tick16) begin
         txTick_q <= txTick_q + 4'h1;
         case (txState_q)
            udh_pkg::TX_IDLE: begin
               txTick_q <= 4'h0;
               if (txPop) begin
                  txShift_q <= txRData;
                  txd_q     <= 1'b0;
                  txState_q <= udh_pkg::TX_START;
               end
            end
            udh_pkg::TX_START: begin
               if (txTick_q == `UDH_OVS_LAST) begin
                  txd_q     <= txShift_q[0];
                  txBit_q   <= 3'h0;
                  txState_q <= udh_pkg::TX_DATA;
               end
            end
            udh_pkg::TX_DATA: begin
               if (txTick_q == `UDH_OVS_LAST) begin
                  txShift_q <= {1'b0, txShift_q[7:1]};
                  txBit_q   <= txBit_q + 3'h1;
                  txd_q     <= (txBit_q == 3'h7) ? 1'b1 : txShift_q[1];
                  if (txBit_q == 3'h7) txState_q <= udh_pkg::TX_STOP;
               end
            end
            default: begin
               if (txTick_q == `UDH_OVS_LAST) txState_q <= udh_pkg::TX_IDLE;
            end
         endcase
      end
   end

   // ***********************************************
   // receiver
   // ***********************************************
   udh_pkg::udh_rx_e rxState_q;
   logic [3:0] rxTick_q;
   logic [2:0] rxBit_q;
   logic [7:0] rxShift_q;
   logic       rxMeta_q;
   logic       rxIn_q;
   logic       frameOk;
   logic       isFlowChar;

   // a good stop bit closes the frame
   assign frameOk    = tick16 && (rxState_q == udh_pkg::RX_STOP)
                     && (rxTick_q == `UDH_OVS_LAST) && rxIn_q;
   // flow characters are consumed, not stored
   assign xonHit     = frameOk && ctrl_q.flowEn && (rxShift_q == `UDH_XON_CHAR);
   assign xoffHit    = frameOk && ctrl_q.flowEn && (rxShift_q == `UDH_XOFF_CHAR);
   assign isFlowChar = xonHit | xoffHit;
   assign specialHit = frameOk && (rxShift_q == special_q);
   assign overrunHit = rxPush_q && !rxWReady;

   always_ff @(posedge mclk) begin
      if (coreRst) begin
         rxMeta_q <= 1'b1;
         rxIn_q   <= 1'b1;
         rxPush_q <= 1'b0;
         rxByte_q <= 8'h00;
      end else if (clkEn) begin
         rxMeta_q <= rxd;
         rxIn_q   <= rxMeta_q;
         rxPush_q <= frameOk && !isFlowChar;
         if (frameOk) rxByte_q <= rxShift_q;
      end
   end

   // start checked mid bit, data sampled each sixteen ticks
   always_ff @(posedge mclk) begin
      if (coreRst) begin
         rxState_q <= udh_pkg::RX_IDLE;
         rxTick_q  <= 4'h0;
         rxBit_q   <= 3'h0;
         rxShift_q <= 8'h00;
      end else if (clkEn && tick16) begin
         rxTick_q <= rxTick_q + 4'h1;
         case (rxState_q)
            udh_pkg::RX_IDLE: begin
               rxTick_q <= 4'h0;
               if (!rxIn_q) rxState_q <= udh_pkg::RX_START;
            end
            udh_pkg::RX_START: begin
               if (rxTick_q == `UDH_OVS_MID) begin
                  rxTick_q  <= 4'h0;
                  rxBit_q   <= 3'h0;
                  rxState_q <= rxIn_q ? udh_pkg::RX_IDLE : udh_pkg::RX_DATA;
               end
            end
            udh_pkg::RX_DATA: begin
               if (rxTick_q == `UDH_OVS_LAST) begin
                  rxShift_q <= {rxIn_q, rxShift_q[7:1]};
                  rxBit_q   <= rxBit_q + 3'h1;
                  if (rxBit_q == 3'h7) rxState_q <= udh_pkg::RX_STOP;
               end
            end
            default: begin
               if (rxTick_q == `UDH_OVS_LAST) rxState_q <= udh_pkg::RX_IDLE;
            end
         endcase
      end
   end

endmodule : udh_uart_core

// ### udh_uart_core_checker.sv
// port checker for the dual style serial controller
`timescale 1ns/1ps

module udh_uart_core_checker (
   // clock and resets
   input wire logic       mclk,
   input wire logic       clkEn,
   input wire logic       rst,
   input wire logic       busStyleSel,
   input wire logic       hostResetPin,
   // host bus
   input wire logic       chipSelN,
   input wire logic       readStrobeN,
   input wire logic       writeStrobeN,
   input wire logic [2:0] registerAddress,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic       dataOe,
   // interrupt and serial
   input wire logic       intOut,
   input wire logic       intOe,
   input wire logic       txd,
   input wire logic       rxd
);
   // ****************
   // port assertions
   // ****************
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_reset_idle: assert property ($fell(rst) |-> txd && dataOut == 8'h00 && !dataOe && !intOe)
      else $error("outputs not idle after reset");
   // pin reset per style; sync delay allowed for
   a_pin_reset: assert property ((busStyleSel == hostResetPin) [*5] |-> txd && !dataOe && !intOe)
      else $error("reset pin did not hold outputs idle");
   a_strobe_read: assert property ((busStyleSel && !chipSelN && !readStrobeN) [*4] |-> dataOe)
      else $error("strobe read did not drive data bus");
   a_strobe_idle: assert property ((busStyleSel && readStrobeN) [*4] |-> !dataOe)
      else $error("data bus driven without read strobe");
   a_dir_read: assert property ((!busStyleSel && !chipSelN && writeStrobeN) [*4] |-> dataOe)
      else $error("direction read did not drive data bus");
   // direction low writes, read strobe ignored
   a_dir_write: assert property ((!busStyleSel && !writeStrobeN) [*4] |-> !dataOe)
      else $error("data bus driven during direction write");
   a_cs_idle: assert property (chipSelN [*4] |-> !dataOe)
      else $error("data bus driven while deselected");
   a_int_drain: assert property (!busStyleSel |-> !intOut)
      else $error("interrupt driven high in direction style");
   // start bit spans sixteen samples, at least eight cycles
   a_start_bit: assert property ($fell(txd) |-> !txd [*8])
      else $error("start bit too short");

   // main scenarios reached
   c_strobe_read: cover property ($rose(dataOe) && busStyleSel);
   c_dir_read: cover property ($rose(dataOe) && !busStyleSel);
   c_frame: cover property ($fell(txd));
endmodule : udh_uart_core_checker

bind udh_uart_core udh_uart_core_checker u_udh_uart_core_checker (
   .mclk(mclk), .clkEn(clkEn), .rst(rst), .busStyleSel(busStyleSel),
   .hostResetPin(hostResetPin), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
   .writeStrobeN(writeStrobeN), .registerAddress(registerAddress), .dataIn(dataIn),
   .dataOut(dataOut), .dataOe(dataOe), .intOut(intOut), .intOe(intOe), .txd(txd),
   .rxd(rxd));

// ### udh_host_model.sv
// host processor model on the parallel register bus
`timescale 1ns/1ps

module udh_host_model (
   // clock and style
   input  wire logic       mclk,
   input  wire logic       busStyleSel,
   // bus pins
   output logic            chipSelN,
   output logic            readStrobeN,
   output logic            writeStrobeN,
   output logic [2:0]      registerAddress,
   output logic [7:0]      dataIn,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOe
);
   // idle bus, strobes high
   initial begin
      chipSelN        = 1'b1;
      readStrobeN     = 1'b1;
      writeStrobeN    = 1'b1;
      registerAddress = 3'h0;
      dataIn          = 8'h00;
   end

   // one access; pins move on falling edges only
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(negedge mclk);
      registerAddress = a;
      dataIn          = d;
      chipSelN        = 1'b0;
      writeStrobeN    = !w;
      // read strobe held low in direction style to prove it is ignored
      readStrobeN     = busStyleSel ? w : 1'b0;
      // long strobe so the synchronised copy is settled
      repeat (6) @(posedge mclk);
      // a released bus reads as the inverse of its last byte
      q = dataOe ? dataOut : ~dataOut;
      @(negedge mclk);
      chipSelN     = 1'b1;
      readStrobeN  = 1'b1;
      writeStrobeN = 1'b1;
      // held past trailing edge detect, then released lines show junk
      repeat (4) @(negedge mclk);
      registerAddress = ~registerAddress;
      dataIn          = ~dataIn;
   endtask : acc
endmodule : udh_host_model

// ### udh_uart_core_tb.sv
// self-checking bench for the dual style serial controller
`timescale 1ns/1ps

module udh_uart_core_tb;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       busStyleSel = 1'b1;
   logic       hostResetPin = 1'b0;
   logic       rxDrv = 1'b1;
   logic       chipSelN, readStrobeN, writeStrobeN, dataOe, intOut, intOe, txd;
   logic [2:0] registerAddress;
   logic [7:0] dataIn, dataOut, q, b;
   int         errors = 0, checksDone = 0, seed = 32664, runLen = 0, lastRun = 0;
   logic [7:0] rstVal [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h04, 8'h81, 8'h00};

   always #5 mclk = ~mclk;

   // loopback anded with a bench line, so idle tx lets injected frames through
   udh_uart_core u_udh_uart_core (
      .mclk(mclk), .clkEn(1'b1), .rst(rst), .busStyleSel(busStyleSel),
      .hostResetPin(hostResetPin), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
      .writeStrobeN(writeStrobeN), .registerAddress(registerAddress), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe), .intOut(intOut), .intOe(intOe), .txd(txd),
      .rxd(txd & rxDrv));
   udh_host_model u_udh_host_model (
      .mclk(mclk), .busStyleSel(busStyleSel), .chipSelN(chipSelN),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
      .registerAddress(registerAddress), .dataIn(dataIn), .dataOut(dataOut),
      .dataOe(dataOe));

   // length of the last low run on the serial output
   always @(posedge mclk) begin
      if (txd === 1'b0) begin
         runLen <= runLen + 1;
      end else begin
         if (runLen != 0) lastRun <= runLen;
         runLen <= 0;
      end
   end

   // *************
   // expectations
   // *************
   function automatic int bitLen(input logic pre4, input logic [7:0] dv);
      return 16 * (pre4 ? 4 : 1) * ((dv == 8'h00) ? 1 : int'(dv));
   endfunction : bitLen
   function automatic logic [7:0] expInt(input logic s, input logic irq);
      return s ? {6'h00, 1'b1, irq} : {6'h00, irq, 1'b0};
   endfunction : expInt

   // *************
   // bench tasks
   // *************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_udh_host_model.acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [2:0] a);
      u_udh_host_model.acc(1'b0, a, 8'h00, q);
   endtask : rd
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : wait_cyc
   task automatic regs;
      for (int a = 1; a < 8; a++) begin
         rd(a[2:0]);
         chk(q, rstVal[a]);
      end
   endtask : regs
   task automatic rw;
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         wr(3'h7, b);
         rd(3'h7);
         chk(q, b);
      end
   endtask : rw
   task automatic frame(input logic pre4, input logic [7:0] dv);
      wr(3'h1, {7'h00, pre4});
      wr(3'h2, dv);
      wr(3'h0, 8'hff);
      wait_cyc(11 * bitLen(pre4, dv) + 40);
      chk(lastRun[7:0], 8'(bitLen(pre4, dv)));
      rd(3'h0);
      chk(q, 8'hff);
   endtask : frame
   task automatic irq_test;
      wr(3'h4, {4'h0, busStyleSel, 3'h0});
      wr(3'h6, 8'h02);
      wr(3'h1, 8'h04);
      for (int j = 0; j < 2; j++) begin
         wr(3'h0, 8'h40 + j[7:0]);
         wait_cyc(220);
         chk({6'h00, intOe, intOut}, expInt(busStyleSel, j == 1));
      end
      for (int j = 0; j < 2; j++) begin
         rd(3'h0);
         chk(q, 8'h40 + j[7:0]);
      end
   endtask : irq_test
   task automatic ser(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxDrv = f[i];
         wait_cyc(16);
      end
   endtask : ser
   task automatic end_sim;
      if (errors == 0 && checksDone > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // watchdog, well beyond the expected run of some six thousand cycles
   initial begin
      #400000;
      errors++;
      end_sim();
   end

   // main sequence
   initial begin
      // reset held far longer than its minimum
      wait_cyc(16);
      rst = 1'b0;
      wait_cyc(6);
      regs();
      rw();
      frame(1'b1, 8'h02);
      frame(1'b0, 8'h03);
      frame(1'b1, 8'h00);
      frame(1'b0, 8'h01);
      // slow line so the transmit queue fills before it drains
      // tx service request on: empty fifo sits at or below threshold 8
      wr(3'h1, 8'h09);
      chk({7'h00, intOut}, 8'h01);
      wr(3'h2, 8'hff);
      for (int i = 0; i < 18; i++) wr(3'h0, 8'h55);
      rd(3'h5);
      chk(q & 8'h02, 8'h02);
      // full fifo above threshold; status read cleared the special flag
      chk({7'h00, intOut}, 8'h00);
      // high pin resets in strobe style
      hostResetPin = 1'b1;
      wait_cyc(8);
      hostResetPin = 1'b0;
      wait_cyc(6);
      regs();
      irq_test();
      // style change passes through a reset of its own
      busStyleSel  = 1'b0;
      hostResetPin = 1'b1;
      wait_cyc(8);
      regs();
      irq_test();
      rw();
      // low pin resets in direction style
      hostResetPin = 1'b0;
      wait_cyc(8);
      hostResetPin = 1'b1;
      wait_cyc(6);
      regs();
      wr(3'h7, 8'h0f);
      wr(3'h1, 8'h02);
      wr(3'h0, 8'h13);
      wait_cyc(220);
      b = {2'b01, 6'($random(seed))};
      wr(3'h0, b);
      wait_cyc(300);
      rd(3'h5);
      chk(q & 8'h15, 8'h10);
      ser(8'h11);
      wait_cyc(220);
      rd(3'h5);
      chk(q & 8'h15, 8'h05);
      rd(3'h0);
      chk(q, b);
      wr(3'h0, 8'h0f);
      wait_cyc(220);
      rd(3'h5);
      chk(q & 8'h09, 8'h09);
      rd(3'h5);
      chk(q & 8'h08, 8'h00);
      rd(3'h0);
      chk(q, 8'h0f);
      end_sim();
   end
endmodule : udh_uart_core_tb
